//--- hdl/rx_err_mon_pkg.sv
// Constants shared by the receive error statistics monitor
package rx_err_mon_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int LINKS_DEF = 4;
  localparam int LINKS_MAX = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Counter widths and limits
  // ----------------------------------------------------------------
  localparam int LEN_CNT_W = 13;
  localparam logic [12:0] LEN_CNT_MAX = 13'h1fff;
  localparam int HT_CNT_W = 12;
  localparam logic [11:0] HT_CNT_MAX = 12'hfff;
  localparam int HT_OVF_BIT = 12;
  localparam int SB_CNT_W = 12;
  localparam logic [11:0] SB_CNT_MAX = 12'hfff;

  // ----------------------------------------------------------------
  // Per-link flag byte layout
  // ----------------------------------------------------------------
  localparam int FLAG_N = 7;
  localparam int FLAG_STRIDE = 8;
  localparam int FLG_LEN_STREAM = 0;
  localparam int FLG_TRIG = 1;
  localparam int FLG_TRIG_ACK = 2;
  localparam int FLG_STREAM = 3;
  localparam int FLG_CTRL_ACK = 4;
  localparam int FLG_LINK_TEST = 5;
  localparam int FLG_HEARTBEAT = 6;

  // ----------------------------------------------------------------
  // Interrupt status layout
  // ----------------------------------------------------------------
  localparam int IRQ_W = 4;
  localparam int IRQ_LEN = 0;
  localparam int IRQ_HT = 1;
  localparam int IRQ_HT_OVF = 2;
  localparam int IRQ_SB = 3;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_LEN_CNT = 8'h00;
  localparam logic [7:0] OFS_HT_CNT = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h20;
  localparam logic [7:0] OFS_SB_CNT = 8'h24;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h2c;
  localparam logic [7:0] OFS_IRQ_EN = 8'h30;

  // ----------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_LEN = 3'h1,
    SEL_HT = 3'h2,
    SEL_FLAGS = 3'h3,
    SEL_SB = 3'h4,
    SEL_STAT = 3'h5,
    SEL_CLR = 3'h6,
    SEL_EN = 3'h7
  } reg_sel_e;

endpackage : rx_err_mon_pkg

//--- hdl/cxp_rx_error_monitor.sv
// Receive error statistics monitor for a multi-link frame grabber
`timescale 1ns/100ps
module cxp_rx_error_monitor #(
  parameter int LINKS = rx_err_mon_pkg::LINKS_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [LINKS-1:0] len_err_evt,
  input wire logic [LINKS-1:0] len_err_stream,
  input wire logic [LINKS-1:0] hdr_fix_evt,
  input wire logic [LINKS-1:0] fix_trig_evt,
  input wire logic [LINKS-1:0] fix_trig_ack_evt,
  input wire logic [LINKS-1:0] fix_stream_evt,
  input wire logic [LINKS-1:0] fix_ctrl_ack_evt,
  input wire logic [LINKS-1:0] fix_link_test_evt,
  input wire logic [LINKS-1:0] fix_heartbeat_evt,
  input wire logic single_fix_evt,
  input wire logic [rx_err_mon_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [rx_err_mon_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [rx_err_mon_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [rx_err_mon_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq
);
  import rx_err_mon_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // The map leaves room for four counters and four flag bytes only
  if (LINKS < 1 || LINKS > LINKS_MAX) begin : g_bad_links
    $error("LINKS must lie between 1 and 4");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [LINKS-1:0][LEN_CNT_W-1:0] len_cnt;
    logic [LINKS-1:0][HT_CNT_W-1:0] ht_cnt;
    logic [LINKS-1:0] ht_ovf;
    logic [LINKS-1:0][FLAG_N-1:0] flags;
    logic [SB_CNT_W-1:0] sb_cnt;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic wr_take;
  logic rd_take;
  reg_sel_e wsel;
  reg_sel_e rsel;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] irq_evt;
  logic [FLAG_N-1:0] fix_set;

  // Address decode shared by the read and write paths
  function automatic reg_sel_e decode(input logic [ADDR_W-1:0] a);
    logic lnk_ok;
    lnk_ok = int'(a[3:2]) < LINKS;
    if (a[1:0] != 2'h0) begin
      decode = SEL_NONE;
    end else if (a[ADDR_W-1:4] == OFS_LEN_CNT[ADDR_W-1:4] && lnk_ok) begin
      decode = SEL_LEN;
    end else if (a[ADDR_W-1:4] == OFS_HT_CNT[ADDR_W-1:4] && lnk_ok) begin
      decode = SEL_HT;
    end else if (a == OFS_FLAGS) begin
      decode = SEL_FLAGS;
    end else if (a == OFS_SB_CNT) begin
      decode = SEL_SB;
    end else if (a == OFS_IRQ_STAT) begin
      decode = SEL_STAT;
    end else if (a == OFS_IRQ_CLR) begin
      decode = SEL_CLR;
    end else if (a == OFS_IRQ_EN) begin
      decode = SEL_EN;
    end else begin
      decode = SEL_NONE;
    end
  endfunction : decode

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  // Address and data are taken together; no write while a response waits
  assign wr_take = awvalid & wvalid & ~st_r.bvalid;
  assign awready = wr_take;
  assign wready = wr_take;
  assign arready = ~st_r.rvalid;
  assign rd_take = arvalid & ~st_r.rvalid;
  assign wsel = decode(awaddr);
  assign rsel = decode(araddr);
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;
  assign irq = |(st_r.irq_stat & st_r.irq_en);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    irq_evt = '0;
    irq_clr = '0;
    fix_set = '0;
    for (int i = 0; i < LINKS; i++) begin
      // Saturate so software never sees a small value after a flood
      if (len_err_evt[i] && st_r.len_cnt[i] != LEN_CNT_MAX) begin
        st_nxt.len_cnt[i] = st_r.len_cnt[i] + 13'h1;
      end
      if (len_err_evt[i] && len_err_stream[i]) begin
        st_nxt.flags[i][FLG_LEN_STREAM] = 1'b1;
      end
      // Count wraps; the sticky overflow bit tells software to ignore it
      if (hdr_fix_evt[i]) begin
        st_nxt.ht_cnt[i] = st_r.ht_cnt[i] + 12'h1;
        if (st_r.ht_cnt[i] == HT_CNT_MAX) begin
          st_nxt.ht_ovf[i] = 1'b1;
          irq_evt[IRQ_HT_OVF] = 1'b1;
        end
      end
      fix_set[FLG_TRIG] = fix_trig_evt[i];
      fix_set[FLG_TRIG_ACK] = fix_trig_ack_evt[i];
      fix_set[FLG_STREAM] = fix_stream_evt[i];
      fix_set[FLG_CTRL_ACK] = fix_ctrl_ack_evt[i];
      fix_set[FLG_LINK_TEST] = fix_link_test_evt[i];
      fix_set[FLG_HEARTBEAT] = fix_heartbeat_evt[i];
      // Flags only ever set; only reset clears them
      st_nxt.flags[i] = st_nxt.flags[i] | fix_set;
    end
    if (single_fix_evt && st_r.sb_cnt != SB_CNT_MAX) begin
      st_nxt.sb_cnt = st_r.sb_cnt + 12'h1;
    end

    // Interrupt status: a new event beats a clear in the same cycle
    irq_evt[IRQ_LEN] = |len_err_evt;
    irq_evt[IRQ_HT] = |hdr_fix_evt;
    irq_evt[IRQ_SB] = single_fix_evt;
    if (wr_take && wsel == SEL_CLR && wstrb[0]) begin
      irq_clr = wdata[IRQ_W-1:0];
    end
    st_nxt.irq_stat = (st_r.irq_stat & ~irq_clr) | irq_evt;

    // Write path
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (wr_take) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      if (wsel == SEL_EN) begin
        if (wstrb[0]) begin
          st_nxt.irq_en = wdata[IRQ_W-1:0];
        end
      end else if (wsel != SEL_CLR) begin
        // Counters and flags are read-only to software
        st_nxt.bresp = RESP_SLVERR;
      end
    end

    // Read path: data registered one cycle after the address is taken
    if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (rd_take) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      st_nxt.rdata = RST_ZERO;
      case (rsel)
        SEL_LEN: begin
          st_nxt.rdata[LEN_CNT_W-1:0] = st_r.len_cnt[araddr[3:2]];
        end
        SEL_HT: begin
          st_nxt.rdata[HT_CNT_W-1:0] = st_r.ht_cnt[araddr[3:2]];
          st_nxt.rdata[HT_OVF_BIT] = st_r.ht_ovf[araddr[3:2]];
        end
        SEL_FLAGS: begin
          for (int i = 0; i < LINKS; i++) begin
            st_nxt.rdata[i*FLAG_STRIDE +: FLAG_N] = st_r.flags[i];
          end
        end
        SEL_SB: begin
          st_nxt.rdata[SB_CNT_W-1:0] = st_r.sb_cnt;
        end
        SEL_STAT: begin
          st_nxt.rdata[IRQ_W-1:0] = st_r.irq_stat;
        end
        SEL_EN: begin
          st_nxt.rdata[IRQ_W-1:0] = st_r.irq_en;
        end
        default: begin
          // Clear register is write-only; unmapped answers an error
          st_nxt.rresp = (rsel == SEL_CLR) ? RESP_OKAY : RESP_SLVERR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_len_count_step: assert property (
    len_err_evt[0] && st_r.len_cnt[0] != LEN_CNT_MAX
    |=> st_r.len_cnt[0] == $past(st_r.len_cnt[0]) + 13'h1)
    else $error("length count did not step");

  a_len_count_sat: assert property (
    st_r.len_cnt[0] == LEN_CNT_MAX |=> st_r.len_cnt[0] == LEN_CNT_MAX)
    else $error("length count left saturation");

  a_stream_len_flag: assert property (
    len_err_evt[0] && len_err_stream[0] |=> st_r.flags[0][FLG_LEN_STREAM])
    else $error("stream length flag not set");

  a_hdr_count_step: assert property (
    hdr_fix_evt[0] |=> st_r.ht_cnt[0] == $past(st_r.ht_cnt[0]) + 12'h1)
    else $error("corrected count did not step");

  a_hdr_overflow: assert property (
    hdr_fix_evt[0] && st_r.ht_cnt[0] == HT_CNT_MAX
    |=> st_r.ht_ovf[0] && st_r.ht_cnt[0] == 12'h0)
    else $error("overflow bit not set on wrap");

  a_trig_flag: assert property (
    fix_trig_evt[0] |=> st_r.flags[0][FLG_TRIG])
    else $error("trigger flag not set");

  a_trig_ack_flag: assert property (
    fix_trig_ack_evt[0] |=> st_r.flags[0][FLG_TRIG_ACK])
    else $error("trigger ack flag not set");

  a_stream_flag: assert property (
    fix_stream_evt[0] |=> st_r.flags[0][FLG_STREAM])
    else $error("stream flag not set");

  a_ctrl_ack_flag: assert property (
    fix_ctrl_ack_evt[0] |=> st_r.flags[0][FLG_CTRL_ACK])
    else $error("control ack flag not set");

  a_link_test_flag: assert property (
    fix_link_test_evt[0] |=> st_r.flags[0][FLG_LINK_TEST])
    else $error("link test flag not set");

  a_heartbeat_flag: assert property (
    fix_heartbeat_evt[0] |=> st_r.flags[0][FLG_HEARTBEAT])
    else $error("heartbeat flag not set");

  a_single_fix_step: assert property (
    single_fix_evt && st_r.sb_cnt != SB_CNT_MAX
    |=> st_r.sb_cnt == $past(st_r.sb_cnt) + 12'h1)
    else $error("single byte count did not step");

  a_flags_sticky: assert property (
    ##1 (st_r.flags & $past(st_r.flags)) == $past(st_r.flags))
    else $error("a flag cleared without reset");

  a_irq_set_wins: assert property (
    len_err_evt[0] |=> st_r.irq_stat[IRQ_LEN])
    else $error("length event lost in status");

  a_len_count_hold: assert property (
    !len_err_evt[0] |=> st_r.len_cnt[0] == $past(st_r.len_cnt[0]))
    else $error("length count moved without an event");

  a_hdr_count_hold: assert property (
    !hdr_fix_evt[0] |=> st_r.ht_cnt[0] == $past(st_r.ht_cnt[0]))
    else $error("corrected count moved without an event");

  a_ovf_sticky: assert property (
    st_r.ht_ovf[0] |=> st_r.ht_ovf[0])
    else $error("overflow bit cleared without reset");

  a_ovf_no_early: assert property (
    !st_r.ht_ovf[0] && !(hdr_fix_evt[0] && st_r.ht_cnt[0] == HT_CNT_MAX) |=> !st_r.ht_ovf[0])
    else $error("overflow bit set before a wrap");

  a_stream_len_qual: assert property (
    !st_r.flags[0][FLG_LEN_STREAM] && !(len_err_evt[0] && len_err_stream[0]) |=> !st_r.flags[0][FLG_LEN_STREAM])
    else $error("stream length flag set without a stream mismatch");

  a_trig_flag_quiet: assert property (
    !fix_trig_evt[0] && !st_r.flags[0][FLG_TRIG] |=> !st_r.flags[0][FLG_TRIG])
    else $error("trigger flag set without an event");

  a_heartbeat_quiet: assert property (
    !fix_heartbeat_evt[0] && !st_r.flags[0][FLG_HEARTBEAT] |=> !st_r.flags[0][FLG_HEARTBEAT])
    else $error("heartbeat flag set without an event");

  a_single_fix_sat: assert property (
    st_r.sb_cnt == SB_CNT_MAX |=> st_r.sb_cnt == SB_CNT_MAX)
    else $error("single byte count left saturation");

  a_single_fix_hold: assert property (
    !single_fix_evt |=> st_r.sb_cnt == $past(st_r.sb_cnt))
    else $error("single byte count moved without an event");

  // Bus answers: one cycle after the take, then standing until accepted
  a_write_answer: assert property (
    awvalid && awready |=> bvalid)
    else $error("write response missing");

  a_read_answer: assert property (
    arvalid && arready |=> rvalid)
    else $error("read data missing");

  a_bvalid_stands: assert property (
    bvalid && !bready |=> bvalid && bresp == $past(bresp))
    else $error("write response dropped before acceptance");

  a_rvalid_stands: assert property (
    rvalid && !rready |=> rvalid && rdata == $past(rdata) && rresp == $past(rresp))
    else $error("read data dropped before acceptance");

  a_no_write_busy: assert property (
    bvalid |-> !awready && !wready)
    else $error("write taken while a response waits");

  a_ro_write_err: assert property (
    wr_take && wsel != SEL_EN && wsel != SEL_CLR |=> bresp == RESP_SLVERR)
    else $error("read-only write not refused");

  a_en_write: assert property (
    wr_take && wsel == SEL_EN && wstrb[0] |=> st_r.irq_en == $past(wdata[IRQ_W-1:0]))
    else $error("enable write did not land");

  a_clear_works: assert property (
    wr_take && wsel == SEL_CLR && wstrb[0] && wdata[IRQ_SB] && !single_fix_evt |=> !st_r.irq_stat[IRQ_SB])
    else $error("status bit not cleared");

  a_clear_loses: assert property (
    wr_take && wsel == SEL_CLR && wstrb[0] && wdata[IRQ_LEN] && len_err_evt != '0 |=> st_r.irq_stat[IRQ_LEN])
    else $error("clear beat a new length event");

endmodule : cxp_rx_error_monitor

//--- bench/pkt_event_src.sv
// Model of the packet receiver that reports parse and correction events
`timescale 1ns/100ps
module pkt_event_src (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fire,
  input wire logic [3:0] kind,
  input wire logic [1:0] link,
  input wire logic stream,
  output logic [3:0] len_err_evt,
  output logic [3:0] len_err_stream,
  output logic [3:0] hdr_fix_evt,
  output logic [3:0] fix_trig_evt,
  output logic [3:0] fix_trig_ack_evt,
  output logic [3:0] fix_stream_evt,
  output logic [3:0] fix_ctrl_ack_evt,
  output logic [3:0] fix_link_test_evt,
  output logic [3:0] fix_heartbeat_evt,
  output logic single_fix_evt
);
  logic [8:0] hit_r;
  logic [1:0] link_r;
  logic stream_r;
  // One event per cycle while fire is held, so bursts look like back-to-back packets
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hit_r <= 9'h000;
      link_r <= 2'h0;
      stream_r <= 1'b0;
    end else begin
      hit_r <= fire ? (9'h001 << kind) : 9'h000;
      link_r <= link;
      stream_r <= stream;
    end
  end
  logic [3:0] lane_mask;
  // Plain net, so a change of link alone still reaches every per-link event output
  assign lane_mask = 4'h1 << link_r;
  // Qualifier means nothing without a length event, so it is scrambled then
  assign len_err_stream = hit_r[0] ? ({4{stream_r}} & lane_mask) : {4{~stream_r}};
  assign len_err_evt = {4{hit_r[0]}} & lane_mask;
  assign hdr_fix_evt = {4{hit_r[1]}} & lane_mask;
  assign fix_trig_evt = {4{hit_r[2]}} & lane_mask;
  assign fix_trig_ack_evt = {4{hit_r[3]}} & lane_mask;
  assign fix_stream_evt = {4{hit_r[4]}} & lane_mask;
  assign fix_ctrl_ack_evt = {4{hit_r[5]}} & lane_mask;
  assign fix_link_test_evt = {4{hit_r[6]}} & lane_mask;
  assign fix_heartbeat_evt = {4{hit_r[7]}} & lane_mask;
  assign single_fix_evt = hit_r[8];
endmodule : pkt_event_src

//--- bench/cxp_rx_error_monitor_tb.sv
// Self-checking bench for the receive error statistics monitor
`timescale 1ns/100ps
module cxp_rx_error_monitor_tb;
  import rx_err_mon_pkg::*;
  logic clk, rst_n, fire, stream, single_fix_evt, irq;
  logic [3:0] kind, len_err_evt, len_err_stream, hdr_fix_evt, fix_trig_evt, fix_trig_ack_evt;
  logic [3:0] fix_stream_evt, fix_ctrl_ack_evt, fix_link_test_evt, fix_heartbeat_evt, wstrb;
  logic [1:0] link, bresp, rresp;
  logic [7:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, flg;
  logic [33:0] rq[$], wq[$];
  int errors, checks_done, cyc, i, n, l, seed;
  // ----
  // Clock, timeout and closing report
  // ----
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Responses are compared in arrival order against the notes left by the drivers
  always @(posedge clk) begin
    if (rvalid && rready) check({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) check({32'h0, bresp}, wq.pop_front());
  end
  // ----
  // Bus and event drivers
  // ----
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    rq.push_back({r, d});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    logic ta, tw;
    wq.push_back({32'h0, r});
    ta = 0;
    tw = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Each channel is released when taken; the design takes both on the same edge
    while (!(ta && tw)) begin
      @(posedge clk);
      if (!ta && awready) begin
        ta = 1;
        awvalid <= 1'b0;
      end
      if (!tw && wready) begin
        tw = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
  endtask : wr
  task automatic ev(input int k, input int lk, input logic s, input int cnt);
    @(posedge clk);
    fire <= 1'b1;
    kind <= 4'(k);
    link <= 2'(lk);
    stream <= s;
    repeat (cnt) @(posedge clk);
    fire <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : ev
  task automatic irq_is(input logic e);
    @(negedge clk);
    check({33'h0, irq}, {33'h0, e});
  endtask : irq_is
  // ----
  // Design and event source
  // ----
  cxp_rx_error_monitor u_dut (.clk(clk), .rst_n(rst_n), .len_err_evt(len_err_evt),
    .len_err_stream(len_err_stream), .hdr_fix_evt(hdr_fix_evt), .fix_trig_evt(fix_trig_evt),
    .fix_trig_ack_evt(fix_trig_ack_evt), .fix_stream_evt(fix_stream_evt), .fix_ctrl_ack_evt(fix_ctrl_ack_evt),
    .fix_link_test_evt(fix_link_test_evt), .fix_heartbeat_evt(fix_heartbeat_evt), .single_fix_evt(single_fix_evt),
    .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq));
  pkt_event_src u_src (.clk(clk), .rst_n(rst_n), .fire(fire), .kind(kind), .link(link), .stream(stream),
    .len_err_evt(len_err_evt), .len_err_stream(len_err_stream), .hdr_fix_evt(hdr_fix_evt),
    .fix_trig_evt(fix_trig_evt), .fix_trig_ack_evt(fix_trig_ack_evt), .fix_stream_evt(fix_stream_evt),
    .fix_ctrl_ack_evt(fix_ctrl_ack_evt), .fix_link_test_evt(fix_link_test_evt),
    .fix_heartbeat_evt(fix_heartbeat_evt), .single_fix_evt(single_fix_evt));
  // ----
  // Scenarios
  // ----
  initial begin
    clk = 0; rst_n = 0; fire = 0; kind = 0; link = 0; stream = 0; flg = 0;
    awaddr = 0; awprot = 0; awvalid = 0; wdata = 0; wstrb = 4'hf; wvalid = 0; bready = 0;
    araddr = 0; arprot = 0; arvalid = 0; rready = 0;
    seed = $urandom(3591);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // Every register reads zero after reset, including the write-only clear
    for (i = 0; i < 13; i++) rd(8'(4 * i), 32'h0);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(OFS_LEN_CNT, 32'h5, RESP_SLVERR);
    // Random per-link length mismatch counts; odd links are stream packets
    for (i = 0; i < 4; i++) begin
      n = $urandom_range(20, 1);
      ev(0, i, i[0], n);
      flg[8 * i] = i[0];
      rd(8'(4 * i), 32'(n));
    end
    rd(OFS_FLAGS, flg);
    // Each corrected packet type sets only its own flag on its own link
    for (i = 1; i < 7; i++) begin
      l = $urandom_range(3, 0);
      ev(i + 1, l, 1'b0, 1);
      flg[8 * l + i] = 1'b1;
      rd(OFS_FLAGS, flg);
    end
    // Header count wraps at 4096 and leaves the overflow bit set
    ev(1, 2, 1'b0, 5);
    rd(OFS_HT_CNT + 8'h08, 32'h5);
    ev(1, 2, 1'b0, 4091);
    rd(OFS_HT_CNT + 8'h08, 32'h1000);
    ev(1, 2, 1'b0, 1);
    rd(OFS_HT_CNT + 8'h08, 32'h1001);
    ev(8, 0, 1'b0, 4100);
    rd(OFS_SB_CNT, 32'hfff);
    ev(0, 3, 1'b0, 8200);
    rd(OFS_LEN_CNT + 8'h0c, 32'h1fff);
    // Interrupt: raise, mask, clear
    rd(OFS_IRQ_STAT, 32'hf);
    irq_is(1'b0);
    wr(OFS_IRQ_EN, 32'h2);
    rd(OFS_IRQ_EN, 32'h2);
    irq_is(1'b1);
    wr(OFS_IRQ_CLR, 32'hf);
    rd(OFS_IRQ_STAT, 32'h0);
    irq_is(1'b0);
    ev(8, 1, 1'b0, 1);
    irq_is(1'b0);
    ev(1, 0, 1'b0, 1);
    irq_is(1'b1);
    rd(OFS_IRQ_STAT, 32'ha);
    // Clear taken at the very edge that sees a length event: the event must win
    fork
      ev(0, 1, 1'b0, 1);
      begin
        @(posedge clk);
        wr(OFS_IRQ_CLR, 32'h1);
      end
    join
    rd(OFS_IRQ_STAT, 32'hb);
    end_sim();
  end
endmodule : cxp_rx_error_monitor_tb
